//--- verilog/tioc_regs.vh
`ifndef TIOC_REGS_VH
`define TIOC_REGS_VH

// ==========================================================
// register byte offsets (apb, one aligned word each)
`define TIOC_OFF_CTRL1     8'h00
`define TIOC_OFF_CTRL2     8'h04
`define TIOC_OFF_FLAGS     8'h08
`define TIOC_OFF_EVT_STAT  8'h0c
`define TIOC_OFF_EVT_MASK  8'h10
`define TIOC_OFF_CAPA      8'h14
`define TIOC_OFF_CAPB      8'h18
`define TIOC_OFF_MATCHA    8'h1c
`define TIOC_OFF_MATCHB    8'h20
`define TIOC_OFF_COUNT     8'h24
`define TIOC_OFF_ALTCOUNT  8'h28

// ==========================================================
// timer_control_one fields
`define TIOC_C1_CAP_IE     7
`define TIOC_C1_MATCH_IE   6
`define TIOC_C1_WRAP_IE    5
`define TIOC_C1_FORCE_B    4
`define TIOC_C1_FORCE_A    3
`define TIOC_C1_LEVEL_B    2
`define TIOC_C1_CAPA_EDGE  1
`define TIOC_C1_LEVEL_A    0

// ==========================================================
// timer_control_two fields
`define TIOC_C2_PIN_EN_A   7
`define TIOC_C2_PIN_EN_B   6
`define TIOC_C2_ONE_SHOT   5
`define TIOC_C2_PWM        4
`define TIOC_C2_CAPB_EDGE  1

// ==========================================================
// flag positions, used in the flag, status and mask words
`define TIOC_FL_CAPA       7
`define TIOC_FL_MATCHA     6
`define TIOC_FL_WRAP       5
`define TIOC_FL_CAPB       4
`define TIOC_FL_MATCHB     3

// ==========================================================
// reset values and counter constants
`define TIOC_CTRL1_RST     8'h00
`define TIOC_CTRL2_RST     8'h00
`define TIOC_MASK_RST      5'h00
`define TIOC_MATCH_RST     16'hffff
`define TIOC_COUNT_RST     16'hfffc
`define TIOC_RELOAD        16'hfffc
`define TIOC_COUNT_TOP     16'hffff

`endif

//--- verilog/tioc_edge_det.v
`timescale 1ns/100ps
// ==========================================================
// pin synchroniser and selectable edge detector
module tioc_edge_det (
  input wire ref_clk,
  input wire reset_n,
  input wire pinIn,
  input wire riseSel,
  output wire edgeHit
);
  reg sync1_r;
  reg sync2_r;
  reg last_r;

  // two stages before any logic; only sync2_r and last_r are examined
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      sync1_r <= pinIn;
      sync2_r <= sync1_r;
      last_r <= sync2_r;
    end
  end

  // 1 selects rising, 0 selects falling
  assign edgeHit = riseSel ? (sync2_r & ~last_r) : (~sync2_r & last_r);
endmodule // tioc_edge_det

//--- verilog/tioc_top.v
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
// Overview of operation
// (R1) all five timer events share one request
// (R2) request needs enable set and global unmask
// (R3) events wake from wait, never from halt
// (R4) no match flags while pwm active
// (R5) capture a flag: capture or pwm period end
// (R6) three control registers, six 16-bit pairs
// (R7) control one resets zero, fully read/write
// (R8) bit 7 enables capture flag requests
// (R9) bit 6 enables match flag requests
// (R10) bit 5 enables wrap flag request
// (R11) bit 4 forces level b onto pin b
// (R12) bit 3 forces level a onto pin a
// (R13) match b copies level b onto pin b
// (R14) one-shot/pwm: match b drives pin a
// (R15) bit 1 picks capture a edge
// (R16) match a copies level a onto pin a
// (R17) pin enables hand pins to timer
// (R18) flag clears after flag read then access
// (R19) request is or of flag and enable
`include "tioc_regs.vh"

module tioc_top (
  input wire ref_clk,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire captureAPin,
  input wire captureBPin,
  input wire cpuIrqMask,
  input wire cpuWaitState,
  input wire cpuHaltState,
  output reg timerIrq,
  output reg wakeRequest,
  output reg eventIrq,
  output reg matchAPin,
  output reg matchAPinOe,
  output reg matchBPin,
  output reg matchBPinOe
);
  // ========================================================
  // register state
  reg [7:0] ctrlOne_r;
  reg [7:0] ctrlTwo_r;
  reg [15:0] count_r;
  reg [15:0] capA_r;
  reg [15:0] capB_r;
  reg [15:0] matchA_r;
  reg [15:0] matchB_r;
  reg [4:0] evtStat_r;
  reg [4:0] evtMask_r;
  reg [4:0] flag_r;
  reg [4:0] armed_r;
  reg [15:0] count_nxt;
  reg [31:0] rdData;
  reg addrOk;

  // ========================================================
  // apb decode: one wait state, effects at the completing edge
  wire accPhase = psel & penable;
  wire commit = accPhase & pready;
  wire wrCommit = commit & pwrite & addrOk;
  wire rdCommit = commit & ~pwrite & addrOk;

  // ========================================================
  // control field views
  wire pwmOn = ctrlTwo_r[`TIOC_C2_PWM];
  wire oneShot = ctrlTwo_r[`TIOC_C2_ONE_SHOT] & ~pwmOn;
  wire pinEnA = ctrlTwo_r[`TIOC_C2_PIN_EN_A];
  wire pinEnB = ctrlTwo_r[`TIOC_C2_PIN_EN_B];

  // ========================================================
  // capture pins, synchronised then edge detected
  wire capAEdge;
  wire capBEdge;

  tioc_edge_det uCapA (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pinIn(captureAPin),
    .riseSel(ctrlOne_r[`TIOC_C1_CAPA_EDGE]), // [R15]
    .edgeHit(capAEdge)
  );

  tioc_edge_det uCapB (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pinIn(captureBPin),
    .riseSel(ctrlTwo_r[`TIOC_C2_CAPB_EDGE]),
    .edgeHit(capBEdge)
  );

  // ========================================================
  // comparators and event sources
  wire run = ~cpuHaltState;
  wire matchAHit = run & (count_r == matchA_r);
  wire matchBHit = run & (count_r == matchB_r);
  wire periodEnd = pwmOn & matchBHit;
  wire shotStart = oneShot & capAEdge;
  wire wrapHit = run & ~periodEnd & ~shotStart &
                 (count_r == `TIOC_COUNT_TOP);
  // capture a pin is disconnected in pwm; a one-shot trigger still flags
  wire capAEvt = (capAEdge & ~pwmOn) | periodEnd; // [R5]
  wire capALoad = capAEdge & ~pwmOn & ~oneShot;
  wire matchAEvt = matchAHit & ~pwmOn & ~oneShot; // [R4]
  wire matchBEvt = matchBHit & ~pwmOn; // [R4]

  // events packed in flag-word order, bit 4 down to bit 0
  wire [4:0] evtSet = {capAEvt, matchAEvt, wrapHit, capBEdge, matchBEvt};

  // ========================================================
  // counter, reloaded at pwm period end or one-shot trigger, frozen while the cpu is halted
  always @* begin
    count_nxt = count_r + 16'h0001;
    if (!run)
      count_nxt = count_r;
    else if (periodEnd || shotStart)
      count_nxt = `TIOC_RELOAD;
  end

  // ========================================================
  // counter and data register pairs
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      count_r <= `TIOC_COUNT_RST;
      capA_r <= 16'h0000;
      capB_r <= 16'h0000;
      matchA_r <= `TIOC_MATCH_RST;
      matchB_r <= `TIOC_MATCH_RST;
    end else begin
      count_r <= count_nxt;
      if (capALoad)
        capA_r <= count_r; // [R6]
      if (capBEdge)
        capB_r <= count_r; // [R6]
      if (wrCommit && paddr == `TIOC_OFF_MATCHA)
        matchA_r <= pwdata[15:0]; // [R6]
      if (wrCommit && paddr == `TIOC_OFF_MATCHB)
        matchB_r <= pwdata[15:0]; // [R6]
    end
  end

  // ========================================================
  // control registers; every bit of control one is read/write
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      ctrlOne_r <= `TIOC_CTRL1_RST; // [R7]
      ctrlTwo_r <= `TIOC_CTRL2_RST;
      evtMask_r <= `TIOC_MASK_RST;
    end else if (wrCommit) begin
      if (paddr == `TIOC_OFF_CTRL1)
        ctrlOne_r <= pwdata[7:0]; // [R7]
      if (paddr == `TIOC_OFF_CTRL2)
        ctrlTwo_r <= pwdata[7:0];
      if (paddr == `TIOC_OFF_EVT_MASK)
        evtMask_r <= pwdata[7:3];
    end
  end

  // ========================================================
  // access to the low half of each flag's own register clears it
  wire [4:0] assocHit;
  assign assocHit[4] = paddr == `TIOC_OFF_CAPA;
  assign assocHit[3] = paddr == `TIOC_OFF_MATCHA;
  assign assocHit[2] = paddr == `TIOC_OFF_COUNT; // alt counter never clears
  assign assocHit[1] = paddr == `TIOC_OFF_CAPB;
  assign assocHit[0] = paddr == `TIOC_OFF_MATCHB;
  wire flagRead = rdCommit & (paddr == `TIOC_OFF_FLAGS);

  // ========================================================
  // per-flag two-step clear; a new event beats the clear
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : gFlag
      wire clrHit = commit & addrOk & assocHit[gi] & armed_r[gi];
      always @(posedge ref_clk) begin
        if (!reset_n) begin
          flag_r[gi] <= 1'b0;
          armed_r[gi] <= 1'b0;
          evtStat_r[gi] <= 1'b0;
        end else begin
          if (evtSet[gi])
            flag_r[gi] <= 1'b1;
          else if (clrHit)
            flag_r[gi] <= 1'b0; // [R18]
          if (clrHit)
            armed_r[gi] <= 1'b0;
          else if (flagRead && flag_r[gi])
            armed_r[gi] <= 1'b1; // [R18]
          // sticky event status, write one to clear
          if (evtSet[gi])
            evtStat_r[gi] <= 1'b1;
          else if (wrCommit && paddr == `TIOC_OFF_EVT_STAT &&
                   pwdata[gi + 3])
            evtStat_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // ========================================================
  // shared request: each flag gated by its enable
  wire capReq = (flag_r[4] | flag_r[1]) &
                ctrlOne_r[`TIOC_C1_CAP_IE]; // [R8]
  wire matchReq = (flag_r[3] | flag_r[0]) &
                  ctrlOne_r[`TIOC_C1_MATCH_IE]; // [R9]
  wire wrapReq = flag_r[2] & ctrlOne_r[`TIOC_C1_WRAP_IE]; // [R10]
  wire anyReq = capReq | matchReq | wrapReq; // [R1] [R19]

  // ========================================================
  // interrupt and wake outputs, registered
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      timerIrq <= 1'b0;
      wakeRequest <= 1'b0;
      eventIrq <= 1'b0;
    end else begin
      timerIrq <= anyReq & ~cpuIrqMask; // [R2]
      // halt freezes the counter and its match and wrap hits; captures still flag, so halt is gated off the wake
      wakeRequest <= anyReq & ~cpuIrqMask & cpuWaitState &
                     ~cpuHaltState; // [R3]
      eventIrq <= |(evtStat_r & evtMask_r);
    end
  end

  // ========================================================
  // compare pins; levels only move while the pin is handed over
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      matchAPin <= 1'b0;
      matchBPin <= 1'b0;
      matchAPinOe <= 1'b0;
      matchBPinOe <= 1'b0;
    end else begin
      matchAPinOe <= pinEnA; // [R17]
      matchBPinOe <= pinEnB; // [R17]
      if (pinEnA) begin
        if (ctrlOne_r[`TIOC_C1_FORCE_A])
          matchAPin <= ctrlOne_r[`TIOC_C1_LEVEL_A]; // [R12]
        else if ((pwmOn || oneShot) && matchBHit)
          matchAPin <= ctrlOne_r[`TIOC_C1_LEVEL_B]; // [R14]
        else if (matchAHit)
          matchAPin <= ctrlOne_r[`TIOC_C1_LEVEL_A]; // [R16]
      end
      if (pinEnB) begin
        if (ctrlOne_r[`TIOC_C1_FORCE_B])
          matchBPin <= ctrlOne_r[`TIOC_C1_LEVEL_B]; // [R11]
        else if (!pwmOn && !oneShot && matchBHit)
          matchBPin <= ctrlOne_r[`TIOC_C1_LEVEL_B]; // [R13]
      end
    end
  end

  // ========================================================
  // read mux and address check
  always @* begin
    rdData = 32'h0000_0000;
    addrOk = 1'b1;
    case (paddr)
      `TIOC_OFF_CTRL1: rdData = {24'h000000, ctrlOne_r};
      `TIOC_OFF_CTRL2: rdData = {24'h000000, ctrlTwo_r};
      `TIOC_OFF_FLAGS: rdData = {24'h000000, flag_r, 3'h0};
      `TIOC_OFF_EVT_STAT: rdData = {24'h000000, evtStat_r, 3'h0};
      `TIOC_OFF_EVT_MASK: rdData = {24'h000000, evtMask_r, 3'h0};
      `TIOC_OFF_CAPA: rdData = {16'h0000, capA_r};
      `TIOC_OFF_CAPB: rdData = {16'h0000, capB_r};
      `TIOC_OFF_MATCHA: rdData = {16'h0000, matchA_r};
      `TIOC_OFF_MATCHB: rdData = {16'h0000, matchB_r};
      `TIOC_OFF_COUNT: rdData = {16'h0000, count_r};
      `TIOC_OFF_ALTCOUNT: rdData = {16'h0000, count_r};
      default: addrOk = 1'b0;
    endcase
  end

  // ========================================================
  // apb answer: pready rises in the second access cycle
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (accPhase && !pready) begin
      pready <= 1'b1;
      pslverr <= ~addrOk;
      prdata <= pwrite ? 32'h0000_0000 : rdData;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule // tioc_top

//--- bench/tioc_top_sva.sv
`timescale 1ns/100ps
// ==========
// apb and interrupt checks on the top ports
module tioc_top_chk (
  input wire ref_clk,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire cpuIrqMask,
  input wire cpuWaitState,
  input wire cpuHaltState,
  input wire timerIrq,
  input wire wakeRequest
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // one wait state, answer only inside an access
  a_ready_wait: assert property ((psel && !penable) |-> ##2 pready)
    else $error("pready not in second access cycle");
  a_ready_acc: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_zero: assert property (pslverr |-> prdata == 32'h0)
    else $error("refused read data not zero");
  // global mask blocks the request a cycle later
  a_irq_mask: assert property (cpuIrqMask |=> !timerIrq)
    else $error("request while masked");
  // clearing all enables drops the request
  a_irq_off: assert property (pready && pwrite && paddr == 8'h00 &&
    pwdata[7:5] == 3'h0 |-> ##2 !timerIrq)
    else $error("request with enables clear");
  // no flag clears without an access, so request holds
  a_irq_hold: assert property (timerIrq && !cpuIrqMask && !pready &&
    !$past(pready) |=> timerIrq)
    else $error("request dropped on its own");
  // wake only from wait, never from halt
  a_wake_src: assert property (wakeRequest |-> timerIrq &&
    $past(cpuWaitState) && !$past(cpuHaltState))
    else $error("wake without cause");
endmodule // tioc_top_chk

bind tioc_top tioc_top_chk u_tioc_top_chk (.ref_clk, .reset_n, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .cpuIrqMask, .cpuWaitState, .cpuHaltState, .timerIrq, .wakeRequest);

//--- bench/tioc_cpu_model.sv
`timescale 1ns/100ps
// ==========
// cpu side: global mask, wait and halt states
module tioc_cpu_model (
  input wire ref_clk,
  input wire reset_n,
  input wire maskCmd,
  input wire waitCmd,
  input wire haltCmd,
  input wire wakeRequest,
  output reg cpuIrqMask,
  output reg cpuWaitState,
  output reg cpuHaltState
);
  // wait ends on a timer wake; halt is left only by command
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      cpuIrqMask <= 1'b1;
      cpuWaitState <= 1'b0;
      cpuHaltState <= 1'b0;
    end else begin
      cpuIrqMask <= maskCmd;
      cpuHaltState <= haltCmd;
      if (wakeRequest)
        cpuWaitState <= 1'b0;
      else if (waitCmd)
        cpuWaitState <= 1'b1;
    end
  end
endmodule // tioc_cpu_model

//--- bench/tioc_top_test.sv
`timescale 1ns/100ps
// ==========
// register level bench
module tioc_top_test;
  reg ref_clk, reset_n, psel, penable, pwrite, capA, er;
  reg maskCmd, waitCmd, haltCmd;
  reg [7:0] paddr;
  reg [15:0] cnt;
  reg [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire pready, pslverr, cpuIrqMask, cpuWaitState, cpuHaltState;
  wire timerIrq, wakeRequest, eventIrq;
  wire matchAPin, matchAPinOe, matchBPin, matchBPinOe;
  integer fail_count, comparisons, i;

  tioc_top u_tioc_top (.ref_clk, .reset_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .captureAPin(capA),
    .captureBPin(1'b0), .cpuIrqMask, .cpuWaitState, .cpuHaltState,
    .timerIrq, .wakeRequest, .eventIrq, .matchAPin, .matchAPinOe,
    .matchBPin, .matchBPinOe);
  tioc_cpu_model u_tioc_cpu_model (.ref_clk, .reset_n, .maskCmd,
    .waitCmd, .haltCmd, .wakeRequest, .cpuIrqMask, .cpuWaitState,
    .cpuHaltState);

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task give_verdict;
    begin
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  task chv(input string n, input [31:0] e, input [31:0] g);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("[ERR] %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task chb(input string n, input e, input g);
    chv(n, {31'h0, e}, {31'h0, g});
  endtask

  task tick(input integer k);
    repeat (k) @(posedge ref_clk);
  endtask

  // one apb transfer; waits for pready under a bound
  task apb(input [7:0] a, input w, input [31:0] d);
    integer n;
    begin
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      @(posedge ref_clk);
      while (pready !== 1'b1 && n < 20) begin
        @(posedge ref_clk);
        n = n + 1;
      end
      if (n >= 20)
        fail_count = fail_count + 1;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task rdc(input [7:0] a, input [31:0] e, input string n);
    begin
      apb(a, 1'b0, 32'h0);
      chv(n, e, rd);
    end
  endtask

  initial begin
    fail_count = 0;
    comparisons = 0;
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    capA = 1'b1;
    maskCmd = 1'b1;
    waitCmd = 1'b0;
    haltCmd = 1'b0;
    tick(8);
    reset_n <= 1'b1;
    rdc(8'h00, 32'h0, "ctrl1");
    wr(8'h00, 32'hff);
    rdc(8'h00, 32'hff, "ctrl1");
    wr(8'h00, 32'h0);
    apb(8'h40, 1'b0, 32'h0);
    chb("slverr", 1'b1, er);
    // counter starts at fffc: wrap and both matches come at once
    rdc(8'h08, 32'h68, "flags");
    maskCmd <= 1'b0;
    for (i = 0; i < 3; i = i + 1) begin
      wr(8'h00, i == 0 ? 32'h40 : i == 1 ? 32'h20 : 32'h80);
      tick(3);
      chb("irq", i != 2, timerIrq);
    end
    wr(8'h00, 32'h20);
    maskCmd <= 1'b1;
    tick(3);
    chb("irq", 1'b0, timerIrq);
    // halt keeps the cpu asleep, wait alone is woken
    maskCmd <= 1'b0;
    haltCmd <= 1'b1;
    tick(3);
    waitCmd <= 1'b1;
    tick(1);
    waitCmd <= 1'b0;
    tick(5);
    chb("wait", 1'b1, cpuWaitState);
    haltCmd <= 1'b0;
    tick(5);
    chb("wait", 1'b0, cpuWaitState);
    chb("evt", 1'b0, eventIrq);
    wr(8'h10, 32'h20);
    tick(3);
    chb("evt", 1'b1, eventIrq);
    wr(8'h0c, 32'h20);
    tick(3);
    chb("evt", 1'b0, eventIrq);
    // alternate counter must not clear wrap, counter must
    apb(8'h28, 1'b0, 32'h0);
    rdc(8'h08, 32'h68, "flags");
    apb(8'h24, 1'b0, 32'h0);
    rdc(8'h08, 32'h48, "flags");
    chb("irq", 1'b0, timerIrq);
    wr(8'h00, 32'h82);
    capA <= 1'b0;
    tick(6);
    rdc(8'h08, 32'h48, "flags");
    capA <= 1'b1;
    tick(6);
    rdc(8'h08, 32'hc8, "flags");
    chb("irq", 1'b1, timerIrq);
    wr(8'h04, 32'hc0);
    wr(8'h00, 32'h19);
    tick(3);
    chb("pinA", 1'b1, matchAPin);
    chb("pinB", 1'b0, matchBPin);
    chb("oeA", 1'b1, matchAPinOe);
    chb("oeB", 1'b1, matchBPinOe);
    wr(8'h00, 32'h1c);
    tick(3);
    chb("pinA", 1'b0, matchAPin);
    chb("pinB", 1'b1, matchBPin);
    // matches well apart so pin a moves before pin b
    wr(8'h00, 32'h01);
    apb(8'h24, 1'b0, 32'h0);
    cnt = rd[15:0];
    wr(8'h1c, {16'h0, cnt + 16'd30});
    wr(8'h20, {16'h0, cnt + 16'd90});
    tick(50);
    chb("pinA", 1'b1, matchAPin);
    chb("pinB", 1'b1, matchBPin);
    tick(50);
    chb("pinB", 1'b0, matchBPin);
    // pwm: match b must move pin a to level b (level b is 0 here)
    wr(8'h04, 32'hd0);
    apb(8'h24, 1'b0, 32'h0);
    cnt = rd[15:0];
    wr(8'h20, {16'h0, cnt + 16'd40});
    tick(60);
    chb("pinA", 1'b0, matchAPin);
    give_verdict;
  end

  // the tests need well under a thousand cycles
  initial begin
    #1000000;
    fail_count = fail_count + 1;
    give_verdict;
  end
endmodule // tioc_top_test
